// *** shared/pci_master_control_pkg.sv ***
// Constants and carrier types of the host-bus master control block
`default_nettype none
package pci_master_control_pkg;
   // Register map
   localparam logic [11:0] CFG_OFFSET   = 12'h080;  // Controller configuration register
   // Field positions
   localparam int RSVD_POS    = 0;                  // Reserved, software keeps low
   localparam int ORDER_POS   = 1;                  // Byte order select
   localparam int SOE_POS     = 2;                  // Stop on error enable
   localparam int PONS_POS    = 3;                  // Parity to system error enable
   localparam int THR_LSB     = 8;                  // Write threshold, low bit
   localparam int THR_W       = 6;                  // Write threshold width
   // Reset values
   localparam logic       ORDER_RST = 1'b1;         // Little-endian after reset
   localparam logic [5:0] THR_RST   = 6'h00;        // Threshold after reset
   // Buffer shape
   localparam int BUF_DEPTH   = 2;                  // Two-entry data buffer
   localparam logic [1:0] BUF_FULL = 2'h2;          // Occupancy when full
   localparam logic [5:0] CNT_MAX  = 6'h3f;         // Dword counter saturates here
   // Configuration fields as held
   typedef struct packed {
      logic [5:0] thr;                              // Write request threshold
      logic       pons;                             // Parity errors onto system error
      logic       soe;                              // Stop on error
      logic       order;                            // 1 = little-endian packet data
      logic       rsvd;                             // Reserved bit, stored as written
   } cfg_t;
   // One word on the data path
   typedef struct packed {
      logic        desc;                            // Descriptor word, never swapped
      logic [31:0] data;                            // Dword, lowest byte in bits 7:0
   } word_t;
   // Error flags from the command/status register
   typedef struct packed {
      logic parity_reported;                        // Data parity reported
      logic target_abort;                           // Received target abort
      logic master_abort;                           // Master abort
      logic system_error;                           // System error signalled
   } err_flags_t;
endpackage
`default_nettype wire

// *** rtl/pci_master_control.sv ***
// Host-bus master control: config register, byte order, request policy, error reporting
`timescale 1ns/1ps
`default_nettype none
module pci_master_control (
   input  wire logic                              core_clk,               // 250 MHz core clock
   input  wire logic                              reset,                  // Synchronous, active high
   // Register port of the bus target
   input  wire logic                              reg_access,             // One-cycle access strobe
   input  wire logic                              reg_write,              // 1 write, 0 read
   input  wire logic [11:0]                       reg_addr,               // Byte address
   input  wire logic [3:0]                        byte_enable_lines_n,    // Active-low byte enables
   input  wire logic [31:0]                       reg_wdata,              // Write data
   output logic [31:0]                            reg_rdata,              // Read data
   output logic                                   reg_ack,                // Access answered
   // Packet data from the receive DMA engine
   input  wire pci_master_control_pkg::word_t     in_word,                // Word, canonical order
   input  wire logic                              in_valid,               // Word offered
   output logic                                   in_ready,               // Buffer can take it
   // Words toward the host bus
   output pci_master_control_pkg::word_t          out_word,               // Word in host order
   output logic                                   out_valid,              // Head word present
   input  wire logic                              out_ready,              // Master takes head
   // Host bus side
   input  wire logic                              bus_clock,              // Bus clock, sampled
   input  wire logic                              bus_grant_in_n,         // Grant, active low
   output logic                                   bus_request_out_n,      // Request, active low
   input  wire pci_master_control_pkg::err_flags_t err_flags,             // Status flags
   input  wire logic                              parity_error_detect,    // One-cycle parity event
   output logic                                   system_error_out_o,     // Open-drain level, low
   output logic                                   system_error_out_oe     // High while pulling low
);
   // Config register and its read answer
   pci_master_control_pkg::cfg_t cfg_r, cfg_nxt;          // Held configuration
   logic [31:0]                  rdata_r, rdata_nxt;      // Read data
   logic                         ack_r, ack_nxt;          // Answer strobe
   // Bus clock and grant synchronisers
   logic bclk_s1_r, bclk_s2_r, bclk_s3_r;                 // Bus clock stages, s3 for edge
   logic gnt_s1_r, gnt_s2_r;                              // Grant stages
   logic bus_rise;                                        // Bus clock rising edge seen
   // Two-entry buffer, head in entry 0
   pci_master_control_pkg::word_t buf_r [pci_master_control_pkg::BUF_DEPTH];
   pci_master_control_pkg::word_t buf_nxt [pci_master_control_pkg::BUF_DEPTH];
   logic [1:0]  occ_r, occ_nxt;                           // Entries held
   logic        in_ready_r, in_ready_nxt;                 // Registered ready
   logic        valid_r, valid_nxt;                       // Head word present, registered
   logic        push, pop;                                // Handshakes
   pci_master_control_pkg::word_t swapped;                // Incoming word in host order
   // Request policy
   logic [5:0]  cnt_r, cnt_nxt;                           // Packet dwords loaded since grant
   logic        req_r, req_nxt;                           // Request, active high inside
   logic        system_error_flag_r, system_error_flag_nxt;                         // System error drive
   logic        blocked;                                  // Error stops mastering
   logic        want;                                     // Threshold reached

   // Byte lanes reversed for big-endian
   function automatic logic [31:0] lane_swap(input logic [31:0] d);
      lane_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

   assign push    = in_valid & in_ready_r;
   assign pop     = out_valid & out_ready;
   assign bus_rise = bclk_s2_r & ~bclk_s3_r;

   // Register decode; any enable asserted writes all bits
   always_comb begin
      logic hit;
      logic live;
      hit       = reg_access & (reg_addr == pci_master_control_pkg::CFG_OFFSET);
      live      = (byte_enable_lines_n != 4'hf);
      cfg_nxt   = cfg_r;
      rdata_nxt = 32'h0000_0000;
      ack_nxt   = reg_access;
      if (hit & live & reg_write) begin
         // Unused bits have no storage, so writes to them vanish
         cfg_nxt.rsvd  = reg_wdata[pci_master_control_pkg::RSVD_POS];
         cfg_nxt.order = reg_wdata[pci_master_control_pkg::ORDER_POS];
         cfg_nxt.soe   = reg_wdata[pci_master_control_pkg::SOE_POS];
         cfg_nxt.pons  = reg_wdata[pci_master_control_pkg::PONS_POS];
         cfg_nxt.thr   = reg_wdata[pci_master_control_pkg::THR_LSB +: pci_master_control_pkg::THR_W];
      end else if (hit & live) begin
         // Read: unused bits return zero
         rdata_nxt[pci_master_control_pkg::RSVD_POS]  = cfg_r.rsvd;
         rdata_nxt[pci_master_control_pkg::ORDER_POS] = cfg_r.order;
         rdata_nxt[pci_master_control_pkg::SOE_POS]   = cfg_r.soe;
         rdata_nxt[pci_master_control_pkg::PONS_POS]  = cfg_r.pons;
         rdata_nxt[pci_master_control_pkg::THR_LSB +: pci_master_control_pkg::THR_W] = cfg_r.thr;
      end
      // No enables: answered with zero, register untouched
   end

   // Register group
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_r   <= '{thr: pci_master_control_pkg::THR_RST, pons: 1'b0, soe: 1'b0,
                      order: pci_master_control_pkg::ORDER_RST, rsvd: 1'b0};
         rdata_r <= 32'h0000_0000;
         ack_r   <= 1'b0;
      end else begin
         cfg_r   <= cfg_nxt;
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
      end
   end

   // Synchronisers; only stage 2 and later feed logic
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bclk_s1_r <= 1'b0;
         bclk_s2_r <= 1'b0;
         bclk_s3_r <= 1'b0;
         gnt_s1_r  <= 1'b1;
         gnt_s2_r  <= 1'b1;
      end else begin
         bclk_s1_r <= bus_clock;
         bclk_s2_r <= bclk_s1_r;
         bclk_s3_r <= bclk_s2_r;
         gnt_s1_r  <= bus_grant_in_n;
         gnt_s2_r  <= gnt_s1_r;
      end
   end

   // Byte order applied on entry; descriptors bypass the swap
   always_comb begin
      swapped = in_word;
      if (!in_word.desc && !cfg_r.order) begin
         swapped.data = lane_swap(in_word.data);
      end
      // Little-endian and descriptors keep lowest byte in 7:0
   end

   // Buffer next state: shift on pop, fill lowest free slot
   always_comb begin
      logic [1:0] after_pop;
      buf_nxt   = buf_r;
      after_pop = occ_r;
      if (pop) begin
         buf_nxt[0] = buf_r[1];
         after_pop  = occ_r - 2'h1;
      end
      if (push) begin
         buf_nxt[after_pop[0]] = swapped;
      end
      occ_nxt      = after_pop + {1'b0, push};
      // Valid kept in its own flop so the output needs no decode
      valid_nxt    = (occ_nxt != 2'h0);
      // Ready is registered, so a full buffer refuses even when popping
      in_ready_nxt = (occ_nxt != pci_master_control_pkg::BUF_FULL);
   end

   // Buffer group
   always_ff @(posedge core_clk) begin
      if (reset) begin
         buf_r[0]   <= '0;
         buf_r[1]   <= '0;
         occ_r      <= 2'h0;
         in_ready_r <= 1'b0;
         valid_r    <= 1'b0;
      end else begin
         buf_r      <= buf_nxt;
         occ_r      <= occ_nxt;
         in_ready_r <= in_ready_nxt;
         valid_r    <= valid_nxt;
      end
   end

   // Request policy; request changes on bus clock edges, error pin sets on a parity event and clears on a bus clock edge
   always_comb begin
      blocked  = cfg_r.soe & (|err_flags);
      want     = (cnt_r != 6'h00) & (cnt_r >= cfg_r.thr);
      cnt_nxt  = cnt_r;
      req_nxt  = req_r;
      system_error_flag_nxt = system_error_flag_r;
      // Grant while requesting starts a burst; the count restarts
      if (req_r & ~gnt_s2_r & bus_rise) begin
         cnt_nxt = 6'h00;
      end
      if (push & ~in_word.desc & (cnt_nxt != pci_master_control_pkg::CNT_MAX)) begin
         cnt_nxt = cnt_nxt + 6'h01;
      end
      if (bus_rise) begin
         req_nxt  = want & ~blocked;
         system_error_flag_nxt = 1'b0;
      end
      // New parity event wins over the edge that ends the pulse
      if (parity_error_detect & cfg_r.pons) begin
         system_error_flag_nxt = 1'b1;
      end
   end

   // Master group
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_r  <= 6'h00;
         req_r  <= 1'b0;
         system_error_flag_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         req_r  <= req_nxt;
         system_error_flag_r <= system_error_flag_nxt;
      end
   end

   // Outputs straight from flops; system_error_out_o tied low
   assign reg_rdata           = rdata_r;
   assign reg_ack             = ack_r;
   assign in_ready            = in_ready_r;
   assign out_word            = buf_r[0];
   assign out_valid           = valid_r;
   assign bus_request_out_n   = ~req_r;
   assign system_error_out_o  = 1'b0;
   assign system_error_out_oe = system_error_flag_r;

   // Checks
   a_order_reset: assert property (@(posedge core_clk)
      $fell(reset) |-> cfg_r.order) else $error("Order bit not high after reset");
   a_big_swap: assert property (@(posedge core_clk) disable iff (reset)
      push && !in_word.desc && !cfg_r.order && occ_r == 2'h0 && !pop
      |=> out_word.data[31:24] == $past(in_word.data[7:0])) else $error("Big-endian lane wrong");
   a_little_keep: assert property (@(posedge core_clk) disable iff (reset)
      push && cfg_r.order && occ_r == 2'h0 && !pop
      |=> out_word.data == $past(in_word.data)) else $error("Little-endian altered");
   a_desc_keep: assert property (@(posedge core_clk) disable iff (reset)
      push && in_word.desc && occ_r == 2'h0 && !pop
      |=> out_word.data == $past(in_word.data)) else $error("Descriptor swapped");
   a_stop_req: assert property (@(posedge core_clk) disable iff (reset)
      bus_rise && cfg_r.soe && (|err_flags) |=> bus_request_out_n) else $error("Request despite error");
   a_go_req: assert property (@(posedge core_clk) disable iff (reset)
      bus_rise && !cfg_r.soe && cnt_r != 6'h00 && cnt_r >= cfg_r.thr
      |=> !bus_request_out_n) else $error("Request withheld");
   a_system_error_flag_drive: assert property (@(posedge core_clk) disable iff (reset)
      parity_error_detect && cfg_r.pons |=> system_error_out_oe) else $error("Parity not reported");
   a_full_write: assert property (@(posedge core_clk) disable iff (reset)
      reg_access && reg_write && reg_addr == pci_master_control_pkg::CFG_OFFSET
      && byte_enable_lines_n != 4'hf
      |=> cfg_r.thr == $past(reg_wdata[13:8]) && cfg_r.soe == $past(reg_wdata[2])) else $error("Write partial");
   a_no_enable: assert property (@(posedge core_clk) disable iff (reset)
      reg_access && byte_enable_lines_n == 4'hf |=> $stable(cfg_r) && reg_rdata == 32'h0000_0000)
      else $error("Access without enables");
   c_full_buf: cover property (@(posedge core_clk) disable iff (reset) occ_r == pci_master_control_pkg::BUF_FULL);
   c_blocked: cover property (@(posedge core_clk) disable iff (reset) blocked && want && bus_rise);
   c_grant: cover property (@(posedge core_clk) disable iff (reset) req_r && !gnt_s2_r && bus_rise);
endmodule // pci_master_control
`default_nettype wire

// *** test/host_bus_model.sv ***
// Host bus partner: free bus clock, grant response, word consumer
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input  wire logic stall,             // Consumer holds off
   input  wire logic grant_en,          // Host arbiter grants
   input  wire logic bus_request_out_n, // Request from block
   output logic      bus_clock,         // Bus clock, free running
   output logic      bus_grant_in_n,    // Grant, active low
   output logic      out_ready          // Consumer takes head
);
   // Bus clock runs free; odd offset keeps it unrelated to core clock
   initial begin
      bus_clock = 1'b0;
      #13;
      forever #40 bus_clock = ~bus_clock;
   end
   // Grant answers a request one bus clock later; one process drives it
   initial begin
      bus_grant_in_n = 1'b1;
      forever @(posedge bus_clock) bus_grant_in_n <= !(grant_en && !bus_request_out_n);
   end
   // Stall follows the bench's falling-edge drive
   assign out_ready = !stall;
endmodule // host_bus_model
`default_nettype wire

// *** test/pci_master_control_tb.sv ***
// Self-checking bench for the host-bus master control block
`timescale 1ns/1ps
`default_nettype none
module pci_master_control_tb;
   logic core_clk, reset, reg_access, reg_write, reg_ack;    // Clock, reset, strobes
   logic [11:0] reg_addr;                                    // Register address
   logic [3:0]  byte_enable_lines_n;                         // Enables, active low
   logic [31:0] reg_wdata, reg_rdata, q;                     // Register data
   pci_master_control_pkg::word_t in_word, out_word;         // Data words
   logic in_valid, in_ready, out_valid, out_ready;           // Data handshake
   logic bus_clock, bus_grant_in_n, bus_request_out_n;       // Host bus lines
   pci_master_control_pkg::err_flags_t err_flags;            // Status flags
   logic parity_error_detect, system_error_out_o, system_error_out_oe;
   logic stall, grant_en;                                    // Partner controls
   int   n_errors, check_count, i;                           // Score and loop
   localparam logic [11:0] CFG = pci_master_control_pkg::CFG_OFFSET;
   pci_master_control i_pci_master_control (.core_clk(core_clk), .reset(reset),
      .reg_access(reg_access), .reg_write(reg_write), .reg_addr(reg_addr),
      .byte_enable_lines_n(byte_enable_lines_n), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .in_word(in_word), .in_valid(in_valid),
      .in_ready(in_ready), .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready),
      .bus_clock(bus_clock), .bus_grant_in_n(bus_grant_in_n),
      .bus_request_out_n(bus_request_out_n), .err_flags(err_flags),
      .parity_error_detect(parity_error_detect), .system_error_out_o(system_error_out_o),
      .system_error_out_oe(system_error_out_oe));
   host_bus_model i_host_bus_model (.stall(stall), .grant_en(grant_en),
      .bus_request_out_n(bus_request_out_n), .bus_clock(bus_clock),
      .bus_grant_in_n(bus_grant_in_n), .out_ready(out_ready));
   // Core clock, 4 ns
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      chk32(what, {31'h0, exp}, {31'h0, got});
   endtask
   // Wait loop ran out: count it and close
   task automatic hang(input string what);
      n_errors++;
      $display("mismatch %s expected change seen none", what);
      test_done();
   endtask
   // One register access; answer sampled one cycle later
   task automatic reg_op(input logic wr, input logic [11:0] a, input logic [3:0] be,
                         input logic [31:0] d);
      reg_access = 1'b1;
      reg_write = wr;
      reg_addr = a;
      byte_enable_lines_n = be;
      reg_wdata = d;
      @(negedge core_clk);
      reg_access = 1'b0;
      chk1("reg_ack", 1'b1, reg_ack);
      q = reg_rdata;
      // Let an edge pass so a following access never re-raises the strobe at once
      @(negedge core_clk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      reg_op(1'b0, a, 4'h0, 32'h0);
      chk32("reg_rdata", exp, q);
   endtask
   task automatic push(input logic desc, input logic [31:0] d);
      in_word = {desc, d};
      in_valid = 1'b1;
      for (i = 0; i < 40 && in_ready !== 1'b1; i++) @(negedge core_clk);
      if (i == 40) hang("in_ready");
      @(negedge core_clk);
      in_valid = 1'b0;
      // Idle edge between words keeps valid from toggling twice in one step
      @(negedge core_clk);
   endtask
   task automatic wait_req(input logic exp);
      for (i = 0; i < 80 && bus_request_out_n !== exp; i++) @(negedge core_clk);
      if (i == 80) hang("bus_request_out_n");
      chk1("bus_request_out_n", exp, bus_request_out_n);
   endtask
   task automatic hold_req(input logic exp);
      logic ok;
      ok = 1'b1;
      repeat (60) begin
         @(negedge core_clk);
         if (bus_request_out_n !== exp) ok = 1'b0;
      end
      chk1("request held", 1'b1, ok);
   endtask
   task automatic t_regs();
      rd_chk(CFG, 32'h00000002);
      reg_op(1'b1, 12'h084, 4'h0, 32'hffffffff);
      rd_chk(12'h084, 32'h0);
      reg_op(1'b1, CFG, 4'h7, 32'hfffffffe);
      rd_chk(CFG, 32'h00003f0e);
      reg_op(1'b1, CFG, 4'hf, 32'h0);
      rd_chk(CFG, 32'h00003f0e);
      reg_op(1'b0, CFG, 4'hf, 32'h0);
      chk32("reg_rdata", 32'h0, q);
      $display("test regs done");
   endtask
   task automatic t_request();
      reg_op(1'b1, CFG, 4'h0, 32'h00000302);
      push(1'b0, 32'h1);
      push(1'b1, 32'h2);
      push(1'b0, 32'h3);
      hold_req(1'b1);
      push(1'b0, 32'h4);
      wait_req(1'b0);
      reg_op(1'b1, CFG, 4'h0, 32'h00000306);
      for (int k = 0; k < 4; k++) begin
         err_flags = 4'h1 << k;
         wait_req(1'b1);
         err_flags = 4'h0;
         wait_req(1'b0);
      end
      err_flags = 4'h2;
      wait_req(1'b1);
      reg_op(1'b1, CFG, 4'h0, 32'h00000302);
      wait_req(1'b0);
      hold_req(1'b0);
      err_flags = 4'h0;
      grant_en = 1'b1;
      wait_req(1'b1);
      $display("test request done");
   endtask
   task automatic t_order();
      stall = 1'b1;
      reg_op(1'b1, CFG, 4'h0, 32'h00000300);
      push(1'b0, 32'h44332211);
      push(1'b1, 32'h88776655);
      chk1("in_ready", 1'b0, in_ready);
      chk32("out_word", 32'h11223344, out_word.data);
      stall = 1'b0;
      @(negedge core_clk);
      stall = 1'b1;
      chk32("out_word", 32'h88776655, out_word.data);
      chk1("out_word.desc", 1'b1, out_word.desc);
      stall = 1'b0;
      repeat (2) @(negedge core_clk);
      chk1("out_valid", 1'b0, out_valid);
      stall = 1'b1;
      reg_op(1'b1, CFG, 4'h0, 32'h00000302);
      push(1'b0, 32'h44332211);
      chk32("out_word", 32'h44332211, out_word.data);
      stall = 1'b0;
      $display("test order done");
   endtask
   task automatic t_system_error_flag(input logic [31:0] cfg, input logic exp);
      reg_op(1'b1, CFG, 4'h0, cfg);
      parity_error_detect = 1'b1;
      @(negedge core_clk);
      parity_error_detect = 1'b0;
      chk1("system_error_out_oe", exp, system_error_out_oe);
      chk1("system_error_out_o", 1'b0, system_error_out_o);
      for (i = 0; i < 80 && system_error_out_oe !== 1'b0; i++) @(negedge core_clk);
      if (i == 80) hang("system_error_out_oe");
      $display("test system error done");
   endtask
   initial begin
      {reg_access, reg_write, in_valid, parity_error_detect, stall, grant_en} = 6'h0;
      {reg_addr, byte_enable_lines_n, reg_wdata, in_word, err_flags} = '0;
      {n_errors, check_count} = 0;
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      t_regs();
      t_request();
      t_order();
      t_system_error_flag(32'h00000302, 1'b0);
      t_system_error_flag(32'h0000030a, 1'b1);
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      rd_chk(CFG, 32'h00000002);
      test_done();
   end
endmodule // pci_master_control_tb
`default_nettype wire
